/* File: design/bds_device.sv */
`timescale 1ns/100ps
// How it works
// [RULE1] write data taken on both input clocks
// [RULE2] low write select starts a write
// [RULE3] deselected write port ignores data bus
// [RULE4] lane selects sampled with their beat
// [RULE5] select 0 bits 8:0, 1 bits 17:9
// [RULE6] deselected lane byte is discarded
// [RULE7] shared address taken on input rise
// [RULE8] 20 address bits in this organisation
// [RULE9] address ignored for deselected port
// [RULE10] read data on output clocks or input
// [RULE11] low read select starts a read
// [RULE12] finish pending read, then float outputs
// [RULE13] each read returns four sequential beats
// [RULE14] accesses start on positive input rise
// [RULE15] both output clocks launch read data
// [RULE16] free-running echo clocks follow output clock
// [RULE17] loop disabled gives one-cycle read latency
// [RULE18] controller alternates read and write addresses
// [RULE19] controller sends four beats over two cycles
module bds_device
    import bds_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    bds_if.device pins
);
    // every flip-flop of this end except the array
    typedef struct packed {
        logic k_prev;
        logic kn_prev;
        logic oc_prev;
        logic ocn_prev;
        bds_wr_state_type wr_state;
        logic [ADDR_W-1:0] wr_addr;
        logic pend_valid;
        logic [LAT_W-1:0] pend_wait;
        logic [ADDR_W-1:0] pend_addr;
        logic [ADDR_W-1:0] act_addr;
        logic [2:0] act_left;
        logic [DATA_W-1:0] q;
        logic q_oe_n;
        logic echo;
        logic echo_n;
    } bds_dev_state_type;

    localparam bds_dev_state_type DEV_RESET = '{
        k_prev: 1'h0,
        kn_prev: 1'h1,
        oc_prev: 1'h0,
        ocn_prev: 1'h1,
        wr_state: BDS_WR_IDLE,
        wr_addr: '0,
        pend_valid: 1'h0,
        pend_wait: '0,
        pend_addr: '0,
        act_addr: '0,
        act_left: 3'h0,
        q: '0,
        q_oe_n: 1'h1,
        echo: 1'h0,
        echo_n: 1'h1
    };

    bds_dev_state_type s_q;
    bds_dev_state_type s_d;

    // the array; contents are undefined until written, like the real cells
    logic [DATA_W-1:0] mem [MEM_WORDS];

    logic k_rise;
    logic kn_rise;
    logic oc;
    logic ocn;
    logic oc_edge;
    logic wr_en;
    logic [MEM_IDX_W-1:0] wr_idx;
    logic [BEAT_W-1:0] rd_beat;

    // clock edges seen as transitions of the sampled clock pins
    assign k_rise = pins.k & ~s_q.k_prev;
    assign kn_rise = pins.k_n & ~s_q.kn_prev;

    // output clock pair, or the input pair in single clock mode
    // [RULE10] launch clock choice
    assign oc = pins.single_clock_mode ? pins.k : pins.c;
    assign ocn = pins.single_clock_mode ? pins.k_n : pins.c_n;
    // [RULE15] both output edges launch
    assign oc_edge = (oc & ~s_q.oc_prev) | (ocn & ~s_q.ocn_prev);

    // beat position inside the burst now leaving the part
    assign rd_beat = BEAT_W'(3'(BURST) - s_q.act_left);

    always_comb begin
        s_d = s_q;
        wr_en = 1'b0;
        wr_idx = '0;
        s_d.k_prev = pins.k;
        s_d.kn_prev = pins.k_n;
        s_d.oc_prev = oc;
        s_d.ocn_prev = ocn;
        // [RULE16] echo tracks the launch clock
        s_d.echo = oc;
        s_d.echo_n = ocn;

        // write burst: beat 0 with the select, then the next three edges
        unique case (s_q.wr_state)
            BDS_WR_IDLE: begin
                // [RULE2] write starts on select
                // [RULE14] only a positive input rise
                if (k_rise && !pins.write_port_select_n) begin
                    // [RULE7] address taken with select
                    s_d.wr_addr = pins.addr;
                    wr_en = 1'b1;
                    wr_idx = bds_mem_index(pins.addr, 2'h0);
                    s_d.wr_state = BDS_WR_BEAT1;
                end
            end
            BDS_WR_BEAT1: begin
                // [RULE1] beat on either input rise
                if (k_rise || kn_rise) begin
                    wr_en = 1'b1;
                    wr_idx = bds_mem_index(s_q.wr_addr, 2'h1);
                    s_d.wr_state = BDS_WR_BEAT2;
                end
            end
            BDS_WR_BEAT2: begin
                if (k_rise || kn_rise) begin
                    wr_en = 1'b1;
                    wr_idx = bds_mem_index(s_q.wr_addr, 2'h2);
                    s_d.wr_state = BDS_WR_BEAT3;
                end
            end
            BDS_WR_BEAT3: begin
                if (k_rise || kn_rise) begin
                    wr_en = 1'b1;
                    wr_idx = bds_mem_index(s_q.wr_addr, 2'h3);
                    s_d.wr_state = BDS_WR_IDLE;
                end
            end
            default: begin
                s_d.wr_state = BDS_WR_IDLE;
            end
        endcase

        // read launch on each output clock edge
        if (oc_edge) begin
            if (s_q.pend_valid && s_q.pend_wait == 2'h1) begin
                // [RULE13] first of four beats
                s_d.act_addr = s_q.pend_addr;
                s_d.act_left = 3'h3;
                s_d.q = mem[bds_mem_index(s_q.pend_addr, 2'h0)];
                s_d.q_oe_n = 1'b0;
                s_d.pend_valid = 1'b0;
            end else if (s_q.act_left != 3'h0) begin
                // [RULE13] remaining sequential beats
                s_d.q = mem[bds_mem_index(s_q.act_addr, rd_beat)];
                s_d.act_left = s_q.act_left - 3'h1;
                s_d.q_oe_n = 1'b0;
            end else begin
                // [RULE12] float after the burst ends
                s_d.q_oe_n = 1'b1;
            end
            if (s_q.pend_valid && s_q.pend_wait > 2'h1) begin
                s_d.pend_wait = s_q.pend_wait - 2'h1;
            end
        end

        // [RULE11] read starts on select
        // [RULE9] address unused while deselected
        if (k_rise && !pins.read_port_select_n) begin
            s_d.pend_valid = 1'b1;
            // [RULE8] all 20 bits kept
            s_d.pend_addr = pins.addr;
            // [RULE17] shorter latency with loop off
            s_d.pend_wait = pins.delay_loop_disable_n ? LAT_DLL_ON :
                LAT_DLL_OFF;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= DEV_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // byte-masked array write; untouched lanes keep old contents
    always_ff @(posedge clk) begin
        for (int i = 0; i < LANES; i++) begin
            // [RULE4] lane select of this beat
            // [RULE5] lane i covers bits 9i+8:9i
            // [RULE6] deselected byte dropped
            // [RULE3] no write without select
            if (wr_en && !pins.byte_lane_write_select_n[i]) begin
                mem[wr_idx][i*LANE_W +: LANE_W] <=
                    pins.d[i*LANE_W +: LANE_W];
            end
        end
    end

    // pins straight from flops
    assign pins.q = s_q.q;
    assign pins.q_oe_n = s_q.q_oe_n;
    assign pins.echo_clock = s_q.echo;
    assign pins.echo_clock_n = s_q.echo_n;
endmodule // bds_device

/* File: design/bds_pkg.sv */
package bds_pkg;
    // data and address widths of the 18-bit organisation
    localparam int DATA_W = 18;
    localparam int ADDR_W = 20;
    localparam int LANE_W = 9;
    localparam int LANES = 2;
    // four transfers per address, two per input clock cycle
    localparam int BURST = 4;
    localparam int BEAT_W = 2;
    // only the low address bits are backed by storage in this model
    localparam int MEM_LOC_W = 8;
    localparam int MEM_WORDS = BURST << MEM_LOC_W;
    localparam int MEM_IDX_W = MEM_LOC_W + BEAT_W;
    // read latency in output clock edges: 1.5 cycles, or 1 with loop off
    localparam int LAT_W = 2;
    localparam logic [LAT_W-1:0] LAT_DLL_ON = 2'h3;
    localparam logic [LAT_W-1:0] LAT_DLL_OFF = 2'h2;
    // top operating rate with the delay loop switched off
    localparam int DLL_OFF_MAX_MHZ = 167;
    localparam int CLK_PERIOD_NS = 10;

    // write burst sequencer of the memory end
    typedef enum logic [3:0] {
        BDS_WR_IDLE = 4'h1,
        BDS_WR_BEAT1 = 4'h2,
        BDS_WR_BEAT2 = 4'h4,
        BDS_WR_BEAT3 = 4'h8
    } bds_wr_state_type;

    // storage slot of one beat of one burst location
    function automatic logic [MEM_IDX_W-1:0] bds_mem_index(
        input logic [ADDR_W-1:0] addr,
        input logic [BEAT_W-1:0] beat
    );
        return {addr[MEM_LOC_W-1:0], beat};
    endfunction
endpackage

/* File: design/bds_if.sv */
`timescale 1ns/100ps
// board wiring between the memory controller and the memory
interface bds_if;
    import bds_pkg::*;
    logic k;
    logic k_n;
    logic c;
    logic c_n;
    logic single_clock_mode;
    logic delay_loop_disable_n;
    logic read_port_select_n;
    logic write_port_select_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] d;
    logic [LANES-1:0] byte_lane_write_select_n;
    logic [DATA_W-1:0] q;
    logic q_oe_n;
    logic echo_clock;
    logic echo_clock_n;

    modport device (
        input k, k_n, c, c_n, single_clock_mode, delay_loop_disable_n,
        input read_port_select_n, write_port_select_n, addr, d,
        input byte_lane_write_select_n,
        output q, q_oe_n, echo_clock, echo_clock_n
    );
    modport controller (
        output k, k_n, c, c_n, single_clock_mode, delay_loop_disable_n,
        output read_port_select_n, write_port_select_n, addr, d,
        output byte_lane_write_select_n,
        input q, q_oe_n, echo_clock, echo_clock_n
    );
endinterface

/* File: design/bds_controller.sv */
`timescale 1ns/100ps
module bds_controller
    import bds_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    bds_if.controller pins,
    input wire logic cfg_single_clock_mode,
    input wire logic cfg_delay_loop_disable_n,
    input wire logic wr_req,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [BURST*DATA_W-1:0] wr_data,
    input wire logic [BURST*LANES-1:0] wr_lane_select_n,
    output logic wr_ready,
    input wire logic rd_req,
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic rd_ready,
    output logic rd_valid,
    output logic [DATA_W-1:0] rd_data
);
    typedef struct packed {
        logic k;
        logic kn;
        logic c;
        logic cn;
        logic single;
        logic dll_n;
        logic rd_slot;
        logic rps_n;
        logic wps_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] d;
        logic [LANES-1:0] bws_n;
        logic wbusy;
        logic [BEAT_W-1:0] wbeat;
        logic wr_ready;
        logic [ADDR_W-1:0] wr_addr;
        logic [BURST*DATA_W-1:0] wr_buf;
        logic [BURST*LANES-1:0] wr_mask_n;
        logic rd_ready;
        logic [ADDR_W-1:0] rd_addr;
        logic echo_prev;
        logic rd_valid;
        logic [DATA_W-1:0] rd_data;
    } bds_ctl_state_type;

    localparam bds_ctl_state_type CTL_RESET = '{
        k: 1'h0,
        kn: 1'h1,
        c: 1'h0,
        cn: 1'h1,
        single: 1'h0,
        dll_n: 1'h1,
        rd_slot: 1'h0,
        rps_n: 1'h1,
        wps_n: 1'h1,
        addr: '0,
        d: '0,
        bws_n: '1,
        wbusy: 1'h0,
        wbeat: 2'h0,
        wr_ready: 1'h1,
        wr_addr: '0,
        wr_buf: '0,
        wr_mask_n: '1,
        rd_ready: 1'h1,
        rd_addr: '0,
        echo_prev: 1'h0,
        rd_valid: 1'h0,
        rd_data: '0
    };

    bds_ctl_state_type s_q;
    bds_ctl_state_type s_d;

    always_comb begin
        s_d = s_q;
        // input clock pair is clk halved; output pair runs in phase with it
        s_d.k = ~s_q.k;
        s_d.kn = s_q.k;
        s_d.c = ~s_q.k;
        s_d.cn = s_q.k;
        s_d.single = cfg_single_clock_mode;
        s_d.dll_n = cfg_delay_loop_disable_n;
        // selects are one clk wide, aligned with a k rise
        s_d.rps_n = 1'b1;
        s_d.wps_n = 1'b1;
        s_d.rd_valid = 1'b0;

        // one request of each kind is held until it goes out
        if (wr_req && s_q.wr_ready) begin
            s_d.wr_ready = 1'b0;
            s_d.wr_addr = wr_addr;
            s_d.wr_buf = wr_data;
            s_d.wr_mask_n = wr_lane_select_n;
        end
        if (rd_req && s_q.rd_ready) begin
            s_d.rd_ready = 1'b0;
            s_d.rd_addr = rd_addr;
        end

        if (s_q.wbusy) begin
            // [RULE19] beats 1..3 on following edges
            // [RULE1] data presented per edge
            s_d.d = s_q.wr_buf[s_q.wbeat*DATA_W +: DATA_W];
            s_d.bws_n = s_q.wr_mask_n[s_q.wbeat*LANES +: LANES];
            s_d.wbeat = s_q.wbeat + 2'h1;
            if (s_q.wbeat == 2'h3) begin
                s_d.wbusy = 1'b0;
                s_d.wr_ready = 1'b1;
            end
        end

        // next update raises k: an access slot
        // [RULE14] selects launched with k rise
        if (!s_q.k) begin
            // [RULE18] read and write slots alternate
            s_d.rd_slot = ~s_q.rd_slot;
            if (s_q.rd_slot) begin
                if (!s_q.rd_ready) begin
                    // [RULE11] read select with address
                    s_d.rps_n = 1'b0;
                    s_d.addr = s_q.rd_addr;
                    s_d.rd_ready = 1'b1;
                end
            end else if (!s_q.wr_ready && !s_q.wbusy) begin
                // [RULE2] write select with beat 0
                // [RULE7] shared address bus
                s_d.wps_n = 1'b0;
                s_d.addr = s_q.wr_addr;
                s_d.d = s_q.wr_buf[0 +: DATA_W];
                s_d.bws_n = s_q.wr_mask_n[0 +: LANES];
                s_d.wbusy = 1'b1;
                s_d.wbeat = 2'h1;
            end
        end

        // read beats captured on each echo clock transition while driven
        s_d.echo_prev = pins.echo_clock;
        if (pins.echo_clock != s_q.echo_prev && !pins.q_oe_n) begin
            s_d.rd_valid = 1'b1;
            s_d.rd_data = pins.q;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= CTL_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // pins and user outputs straight from flops
    assign pins.k = s_q.k;
    assign pins.k_n = s_q.kn;
    assign pins.c = s_q.c;
    assign pins.c_n = s_q.cn;
    assign pins.single_clock_mode = s_q.single;
    assign pins.delay_loop_disable_n = s_q.dll_n;
    assign pins.read_port_select_n = s_q.rps_n;
    assign pins.write_port_select_n = s_q.wps_n;
    assign pins.addr = s_q.addr;
    assign pins.d = s_q.d;
    assign pins.byte_lane_write_select_n = s_q.bws_n;
    assign wr_ready = s_q.wr_ready;
    assign rd_ready = s_q.rd_ready;
    assign rd_valid = s_q.rd_valid;
    assign rd_data = s_q.rd_data;
endmodule // bds_controller

/* File: verification/bds_checker.sv */
`timescale 1ns/100ps
// pin-level watch on the link between controller and memory
module bds_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic k,
    input wire logic k_n,
    input wire logic delay_loop_disable_n,
    input wire logic read_port_select_n,
    input wire logic write_port_select_n,
    input wire logic q_oe_n,
    input wire logic echo_clock,
    input wire logic echo_clock_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_sel_on_k: assert property (
        (!write_port_select_n || !read_port_select_n) |-> k)
        else $error("port select away from a k rise");
    // one write per two k cycles
    a_wsel_spacing: assert property (
        !write_port_select_n |=> write_port_select_n[*3])
        else $error("write selects too close");
    // one read per two k cycles
    a_rsel_spacing: assert property (
        !read_port_select_n |=> read_port_select_n[*3])
        else $error("read selects too close");
    a_k_pair: assert property (k_n == !k)
        else $error("input clock pair not complementary");
    a_k_toggle: assert property (k |=> !k)
        else $error("input clock stuck high");
    // four beats, latency with loop on
    a_lat_loop_on: assert property (
        (!read_port_select_n && delay_loop_disable_n)
        |-> ##4 (!q_oe_n)[*4])
        else $error("read burst late or short, loop on");
    a_lat_loop_off: assert property (
        (!read_port_select_n && !delay_loop_disable_n)
        |-> ##3 (!q_oe_n)[*4])
        else $error("read burst late or short, loop off");
    a_burst_end: assert property (
        $fell(q_oe_n) |-> ##4 (q_oe_n || !$past(read_port_select_n, 4)
        || !$past(read_port_select_n, 3)))
        else $error("read outputs not floated after burst");
    a_echo_pair: assert property (echo_clock_n == !echo_clock)
        else $error("echo pair not complementary");
    a_echo_runs: assert property (echo_clock |=> !echo_clock)
        else $error("echo clock stuck high");
endmodule // bds_checker

/* File: verification/testbench.sv */
`timescale 1ns/100ps
module testbench;
    import bds_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic scm, dln, wr_req, rd_req, wr_ready, rd_ready, rd_valid;
    logic [ADDR_W-1:0] wr_addr, rd_addr;
    logic [BURST*DATA_W-1:0] wr_data;
    logic [BURST*LANES-1:0] wr_sel_n;
    logic [DATA_W-1:0] rd_data;
    logic [DATA_W-1:0] mem [MEM_WORDS];
    logic [31:0] r;
    logic [MEM_LOC_W-1:0] loc;
    int seed = 36308;
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;

    bds_if ifc();
    bds_device i_bds_device (.clk(clk), .rst_n(rst_n), .pins(ifc.device));
    bds_controller i_bds_controller (.clk(clk), .rst_n(rst_n),
        .pins(ifc.controller), .cfg_single_clock_mode(scm),
        .cfg_delay_loop_disable_n(dln), .wr_req(wr_req), .wr_addr(wr_addr),
        .wr_data(wr_data), .wr_lane_select_n(wr_sel_n),
        .wr_ready(wr_ready), .rd_req(rd_req), .rd_addr(rd_addr),
        .rd_ready(rd_ready), .rd_valid(rd_valid), .rd_data(rd_data));
    bds_checker i_bds_checker (.clk(clk), .rst_n(rst_n), .k(ifc.k),
        .k_n(ifc.k_n), .delay_loop_disable_n(ifc.delay_loop_disable_n),
        .read_port_select_n(ifc.read_port_select_n),
        .write_port_select_n(ifc.write_port_select_n),
        .q_oe_n(ifc.q_oe_n), .echo_clock(ifc.echo_clock),
        .echo_clock_n(ifc.echo_clock_n));

    // free-running system clock
    always #(CLK_PERIOD_NS / 2) clk = ~clk;

    task automatic report_and_stop;
        if (num_errors == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // hang guard, generous against the 96 ops
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            report_and_stop;
        end
    end

    // lanes with select high keep the old byte
    function automatic logic [DATA_W-1:0] merge(
        input logic [DATA_W-1:0] old, input logic [DATA_W-1:0] nw,
        input logic [LANES-1:0] sel_n);
        logic [DATA_W-1:0] m;
        m = old;
        for (int l = 0; l < LANES; l++) begin
            if (!sel_n[l]) m[l*LANE_W +: LANE_W] = nw[l*LANE_W +: LANE_W];
        end
        return m;
    endfunction

    function automatic logic [BURST*DATA_W-1:0] rnd_burst();
        logic [95:0] t;
        t = {$random(seed), $random(seed), $random(seed)};
        return t[BURST*DATA_W-1:0];
    endfunction

    task automatic check_data(input logic [DATA_W-1:0] got,
        input logic [DATA_W-1:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %0t: data %h wanted %h", $time, got, exp);
        end
    endtask

    task automatic check_flag(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %0t: flag %b wanted %b", $time, got, exp);
        end
    endtask

    // inputs always move 1 ns after the rising edge
    task automatic step;
        @(posedge clk);
        #1;
    endtask

    task automatic do_write(input logic [ADDR_W-1:0] a,
        input logic [BURST*DATA_W-1:0] dat, input logic [BURST*LANES-1:0] s);
        int n;
        wr_addr = a;
        wr_data = dat;
        wr_sel_n = s;
        wr_req = 1'b1;
        n = 0;
        while (wr_ready !== 1'b1 && n < 40) begin
            step;
            n++;
        end
        step;
        wr_req = 1'b0;
        for (int b = 0; b < BURST; b++) begin
            mem[{a[MEM_LOC_W-1:0], 2'(b)}] = merge(
                mem[{a[MEM_LOC_W-1:0], 2'(b)}],
                dat[b*DATA_W +: DATA_W], s[b*LANES +: LANES]);
        end
        n = 0;
        while (wr_ready !== 1'b1 && n < 40) begin
            step;
            n++;
        end
    endtask

    task automatic do_read(input logic [ADDR_W-1:0] a);
        int n;
        rd_addr = a;
        rd_req = 1'b1;
        n = 0;
        while (rd_ready !== 1'b1 && n < 40) begin
            step;
            n++;
        end
        step;
        rd_req = 1'b0;
        n = 0;
        while (rd_valid !== 1'b1 && n < 40) begin
            step;
            n++;
        end
        for (int b = 0; b < BURST; b++) begin
            check_flag(rd_valid, 1'b1);
            check_data(rd_data, mem[{a[MEM_LOC_W-1:0], 2'(b)}]);
            step;
        end
        check_flag(rd_valid, 1'b0);
    endtask

    initial begin
        {wr_req, rd_req, wr_addr, rd_addr, wr_data} = '0;
        wr_sel_n = 8'hFF;
        scm = 1'b0;
        dln = 1'b1;
        repeat (12) @(posedge clk);
        #1 rst_n = 1'b1;
        // fill every location used later, all lanes on
        for (int l = 0; l < 16; l++) begin
            r = $random(seed);
            do_write({r[ADDR_W-1:8], 8'(l)}, rnd_burst(), 8'h00);
        end
        // each pairing of single clock mode and loop disable
        for (int m = 0; m < 4; m++) begin
            scm = m[0];
            dln = !m[1];
            repeat (8) step;
            do_write({12'hFFF, 8'h00}, rnd_burst(), 8'hFF);
            do_read({12'hABC, 8'h00});
            for (int i = 0; i < 6; i++) begin
                r = $random(seed);
                loc = {4'h0, r[3:0]};
                // write and read overlap on separate locations
                fork
                    do_write({r[19:8], loc}, rnd_burst(), r[15:8]);
                    do_read({r[31:20], loc ^ 8'h01});
                join
                do_read({r[27:16], loc});
            end
        end
        report_and_stop;
    end
endmodule // testbench
